// ==== hdl/power_domain_transition_err.sv ====
/*
 Error pending and clear registers, go command and transition status of
 the always-on power domain and its 41 modules, with its interrupt logic.
 Assumes the rest of the controller supplies event levels, next-state and
 current-state fields synchronous to core_clk, and follows the requests.
*/
// The strobed register port and the register offsets were left to the implementer.
`timescale 1ns/1ns
`include "pdt_params.svh"

module power_domain_transition_err (
	// Clock and reset
	input wire logic core_clk,
	input wire logic arst_n,
	// Register port
	input wire pdt_pkg::reg_req_s bus_req,
	output logic [`PDT_DW-1:0] bus_rdata,
	// Error events and flag clears
	input wire pdt_pkg::mod_vec_t mod_event,
	input wire logic dom_event,
	output pdt_pkg::mod_vec_t mod_flag_clr,
	// Next and current states
	input wire pdt_pkg::mod_vec_t mod_next,
	input wire pdt_pkg::mod_vec_t mod_cur,
	input wire pdt_pkg::pwr_state_e dom_next,
	input wire pdt_pkg::pwr_state_e dom_cur,
	// Transition requests
	output pdt_pkg::mod_vec_t mod_req,
	output pdt_pkg::mod_vec_t mod_target,
	output logic dom_req,
	output pdt_pkg::pwr_state_e dom_target,
	// Interrupts
	output logic power_sleep_irq,
	output logic irq
);
	import pdt_pkg::*;

	// ------------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------------
	wire logic hit_eval = bus_req.addr == `PDT_OFS_EVAL;
	wire logic hit_mplo = bus_req.addr == `PDT_OFS_MPEND_LO;
	wire logic hit_mphi = bus_req.addr == `PDT_OFS_MPEND_HI;
	wire logic hit_mclo = bus_req.addr == `PDT_OFS_MCLR_LO;
	wire logic hit_mchi = bus_req.addr == `PDT_OFS_MCLR_HI;
	wire logic hit_dpend = bus_req.addr == `PDT_OFS_DPEND;
	wire logic hit_dclr = bus_req.addr == `PDT_OFS_DCLR;
	wire logic hit_tcmd = bus_req.addr == `PDT_OFS_TCMD;
	wire logic hit_tstat = bus_req.addr == `PDT_OFS_TSTAT;
	wire logic hit_istat = bus_req.addr == `PDT_OFS_ISTAT;
	wire logic hit_imask = bus_req.addr == `PDT_OFS_IMASK;

	// Write commands; only the documented bits act, the rest are ignored
	wire logic [`PDT_NLOW-1:0] clr_lo = (bus_req.wr && hit_mclo) ?
		bus_req.wdata[`PDT_NLOW-1:0] : '0;
	wire logic [`PDT_NHIGH-1:0] clr_hi = (bus_req.wr && hit_mchi) ?
		bus_req.wdata[`PDT_NHIGH-1:0] : '0;
	wire mod_vec_t mod_clr = {clr_hi, clr_lo};
	wire logic dom_clr = bus_req.wr && hit_dclr && bus_req.wdata[`PDT_BIT0];
	wire logic go_wr = bus_req.wr && hit_tcmd && bus_req.wdata[`PDT_BIT0];
	wire logic eval_wr = bus_req.wr && hit_eval && bus_req.wdata[`PDT_BIT0];

	// ------------------------------------------------------------------
	// Pending flags
	// ------------------------------------------------------------------
	mod_vec_t mpend_reg;
	mod_vec_t mpend_next;
	logic dpend_reg;
	logic dpend_next;

	// Set beats clear, so an event landing on the clear write is kept
	assign mpend_next = (mpend_reg & ~mod_clr) | mod_event;
	assign dpend_next = (dpend_reg & ~dom_clr) | dom_event;

	// The module status flags live elsewhere; they get the same strobe
	assign mod_flag_clr = mod_clr;

	// Pending registers
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			mpend_reg <= `PDT_RST_MOD;
			dpend_reg <= 1'b0;
		end else begin
			mpend_reg <= mpend_next;
			dpend_reg <= dpend_next;
		end
	end

	// ------------------------------------------------------------------
	// Transition engine
	// ------------------------------------------------------------------
	mod_vec_t mreq_reg;
	mod_vec_t mreq_next;
	mod_vec_t mtgt_reg;
	mod_vec_t mtgt_next;
	logic dreq_reg;
	logic dreq_next;
	pwr_state_e dtgt_reg;
	pwr_state_e dtgt_next;

	// A request stays up until the current state reaches its target.
	// Next fields are sampled only at go, so later edits wait for a new go.
	wire mod_vec_t mod_diff = mod_next ^ mod_cur;
	wire logic dom_diff = dom_next != dom_cur;
	wire mod_vec_t mod_hold = mreq_reg & (mtgt_reg ^ mod_cur);
	wire logic dom_hold = dreq_reg && (dtgt_reg != dom_cur);
	assign mreq_next = go_wr ? (mod_diff | mod_hold) : mod_hold;
	assign mtgt_next = go_wr ? mod_next : mtgt_reg;
	assign dreq_next = go_wr ? (dom_diff || dom_hold) : dom_hold;
	assign dtgt_next = go_wr ? dom_next : dtgt_reg;

	// Request and target registers
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			mreq_reg <= `PDT_RST_MOD;
			mtgt_reg <= `PDT_RST_MOD;
			dreq_reg <= 1'b0;
			dtgt_reg <= PWR_OFF;
		end else begin
			mreq_reg <= mreq_next;
			mtgt_reg <= mtgt_next;
			dreq_reg <= dreq_next;
			dtgt_reg <= dtgt_next;
		end
	end

	assign mod_req = mreq_reg;
	assign mod_target = mtgt_reg;
	assign dom_req = dreq_reg;
	assign dom_target = dtgt_reg;

	// Transition in progress flag
	wire logic busy = dreq_reg || (|mreq_reg);

	// ------------------------------------------------------------------
	// Interrupts
	// ------------------------------------------------------------------
	logic busy_d_reg;
	logic armed_reg;
	logic armed_next;
	logic [`PDT_NEVT-1:0] istat_reg;
	logic [`PDT_NEVT-1:0] istat_next;
	logic [`PDT_NEVT-1:0] imask_reg;

	// Events: transition finished, new module error, new domain error
	wire logic [`PDT_NEVT-1:0] evt = {
		dom_event && !dpend_reg,
		|(mod_event & ~mpend_reg),
		busy_d_reg && !busy
	};
	wire logic [`PDT_NEVT-1:0] istat_clr = (bus_req.wr && hit_istat) ?
		bus_req.wdata[`PDT_NEVT-1:0] : '0;
	assign istat_next = (istat_reg & ~istat_clr) | evt;

	// The controller line drops once raised and returns only on an
	// evaluate write, so software re-checks sources before a new edge.
	wire logic any_pend = dpend_reg || (|mpend_reg);
	assign armed_next = eval_wr ? 1'b1 : (armed_reg && !any_pend);
	assign power_sleep_irq = armed_reg && any_pend;
	assign irq = |(istat_reg & imask_reg);

	// Interrupt registers
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			busy_d_reg <= 1'b0;
			armed_reg <= 1'b1;
			istat_reg <= `PDT_RST_EVT;
			imask_reg <= `PDT_RST_EVT;
		end else begin
			busy_d_reg <= busy;
			armed_reg <= armed_next;
			istat_reg <= istat_next;
			if (bus_req.wr && hit_imask) begin
				imask_reg <= bus_req.wdata[`PDT_NEVT-1:0];
			end
		end
	end

	// ------------------------------------------------------------------
	// Read data
	// ------------------------------------------------------------------
	// Write-only, reserved and unmapped locations all return zero
	logic [`PDT_DW-1:0] rsel;
	always_comb begin
		rsel = `PDT_ZERO32;
		if (hit_mplo) begin
			rsel = mpend_reg[`PDT_NLOW-1:0];
		end else if (hit_mphi) begin
			rsel[`PDT_NHIGH-1:0] = mpend_reg[`PDT_NMOD-1:`PDT_NLOW];
		end else if (hit_dpend) begin
			rsel[`PDT_BIT0] = dpend_reg;
		end else if (hit_tstat) begin
			rsel[`PDT_BIT0] = busy;
		end else if (hit_istat) begin
			rsel[`PDT_NEVT-1:0] = istat_reg;
		end else if (hit_imask) begin
			rsel[`PDT_NEVT-1:0] = imask_reg;
		end
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			bus_rdata <= `PDT_ZERO32;
		end else begin
			bus_rdata <= bus_req.rd ? rsel : `PDT_ZERO32;
		end
	end

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	sequence s_go;
		go_wr;
	endsequence
	sequence s_idle_after;
		##1 !busy;
	endsequence

	a_low_clear_works: assert property (@(posedge core_clk) disable iff (!arst_n)
		(clr_lo[5] && !mod_event[5]) |=> !mpend_reg[5])
		else $error("low clear did not clear pending");
	a_high_clear_works: assert property (@(posedge core_clk) disable iff (!arst_n)
		(bus_req.wr && hit_mchi && bus_req.wdata[8] && !mod_event[40]) |=> !mpend_reg[40])
		else $error("high clear did not clear pending");
	a_clear_strobe_pairs: assert property (@(posedge core_clk) disable iff (!arst_n)
		mod_flag_clr[0] |-> (bus_req.wr && hit_mclo && bus_req.wdata[0]))
		else $error("flag clear without clear write");
	a_domain_pend_read: assert property (@(posedge core_clk) disable iff (!arst_n)
		(bus_req.rd && hit_dpend) |=> bus_rdata == {31'h0, $past(dpend_reg)})
		else $error("domain pending read wrong");
	a_domain_clear_works: assert property (@(posedge core_clk) disable iff (!arst_n)
		(dom_clr && !dom_event) |=> !dpend_reg)
		else $error("domain clear failed");
	a_go_starts_move: assert property (@(posedge core_clk) disable iff (!arst_n)
		s_go ##0 dom_diff |=> dom_req && dom_target == $past(dom_next))
		else $error("go did not start domain move");
	a_match_untouched: assert property (@(posedge core_clk) disable iff (!arst_n)
		(go_wr && !mod_diff[0] && !mreq_reg[0]) |=> !mod_req[0])
		else $error("matching module was requested");
	a_status_tracks_req: assert property (@(posedge core_clk) disable iff (!arst_n)
		(bus_req.rd && hit_tstat) |=> bus_rdata[0] == $past(busy))
		else $error("transition status read wrong");
	a_status_returns_idle: assert property (@(posedge core_clk) disable iff (!arst_n)
		(busy && !go_wr && mod_cur == mtgt_reg && dom_cur == dtgt_reg) |-> s_idle_after)
		else $error("status stuck after completion");
	a_event_wins_clear: assert property (@(posedge core_clk) disable iff (!arst_n)
		(mod_clr[5] && mod_event[5]) |=> mpend_reg[5])
		else $error("event lost on clear");
	a_eval_reasserts: assert property (@(posedge core_clk) disable iff (!arst_n)
		(eval_wr && any_pend && !(|mod_clr) && !dom_clr) |=> power_sleep_irq)
		else $error("evaluate did not reassert");
	a_reserved_zero: assert property (@(posedge core_clk) disable iff (!arst_n)
		(bus_req.rd && (hit_mclo || hit_tcmd)) |=> bus_rdata == `PDT_ZERO32)
		else $error("write-only register read nonzero");

	// Domain move still owed: current state has not reached the target
	sequence s_dom_move;
		dom_req && (dom_target != dom_cur);
	endsequence

	// Requests must not drop early, or the status would lie to a poller
	a_hold_until_done: assert property (@(posedge core_clk) disable iff (!arst_n)
		s_dom_move |=> dom_req)
		else $error("domain request dropped before completion");
	a_status_set_on_go: assert property (@(posedge core_clk) disable iff (!arst_n)
		s_go ##0 (|mod_diff) |=> busy)
		else $error("status not set after go");
	a_go_zero_inert: assert property (@(posedge core_clk) disable iff (!arst_n)
		(bus_req.wr && hit_tcmd && !bus_req.wdata[`PDT_BIT0] && !busy) |=> !busy)
		else $error("go write of zero started a move");

	// Pending flags follow their events one edge later
	a_module_pend_set: assert property (@(posedge core_clk) disable iff (!arst_n)
		mod_event[0] |=> mpend_reg[0])
		else $error("module event did not set pending");
	a_domain_pend_set: assert property (@(posedge core_clk) disable iff (!arst_n)
		dom_event |=> dpend_reg)
		else $error("domain event did not set pending");

	// The controller line is a one-cycle level until the next evaluate
	a_irq_drops_once: assert property (@(posedge core_clk) disable iff (!arst_n)
		(power_sleep_irq && !eval_wr) |=> !power_sleep_irq)
		else $error("controller interrupt did not drop");

	// Reserved bits and idle read cycles must return zero
	a_high_reserved_read: assert property (@(posedge core_clk) disable iff (!arst_n)
		(bus_req.rd && hit_mphi) |=> bus_rdata[`PDT_DW-1:`PDT_NHIGH] == '0)
		else $error("reserved high pending bits nonzero");
	a_rdata_one_cycle: assert property (@(posedge core_clk) disable iff (!arst_n)
		!bus_req.rd |=> bus_rdata == `PDT_ZERO32)
		else $error("read data outside its cycle");

endmodule

// ==== hdl/pdt_params.svh ====
/*
 Register offsets, field positions, widths and reset values of the power
 domain transition and error block.
 Assumes inclusion by bare name from the package and the design module.
*/
`ifndef PDT_PARAMS_SVH
`define PDT_PARAMS_SVH

// ----------------------------------------------------------------------
// Widths
// ----------------------------------------------------------------------
`define PDT_AW 12
`define PDT_DW 32
`define PDT_NMOD 41
`define PDT_NLOW 32
`define PDT_NHIGH 9
`define PDT_NEVT 3

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define PDT_OFS_EVAL 12'h018
`define PDT_OFS_MPEND_LO 12'h040
`define PDT_OFS_MPEND_HI 12'h044
`define PDT_OFS_MCLR_LO 12'h050
`define PDT_OFS_MCLR_HI 12'h054
`define PDT_OFS_DPEND 12'h060
`define PDT_OFS_DCLR 12'h068
`define PDT_OFS_TCMD 12'h120
`define PDT_OFS_TSTAT 12'h128
`define PDT_OFS_ISTAT 12'h070
`define PDT_OFS_IMASK 12'h074

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define PDT_BIT0 0
`define PDT_EVT_DONE 0
`define PDT_EVT_MERR 1
`define PDT_EVT_DERR 2
`define PDT_ZERO32 32'h00000000
`define PDT_RST_MOD 41'h00000000000
`define PDT_RST_EVT 3'h0

`endif

// ==== hdl/pdt_pkg.sv ====
/*
 Types shared by the power domain transition and error block.
 Assumes pdt_params.svh is on the include path.
*/
`include "pdt_params.svh"

package pdt_pkg;

	// Domain and module state encoding
	typedef enum logic [0:0] {
		PWR_OFF = 1'b0,
		PWR_ON = 1'b1
	} pwr_state_e;

	// One register bus request
	typedef struct packed {
		logic [`PDT_AW-1:0] addr;
		logic [`PDT_DW-1:0] wdata;
		logic wr;
		logic rd;
	} reg_req_s;

	typedef logic [`PDT_NMOD-1:0] mod_vec_t;

endpackage

// ==== verification/tb_power_domain_transition_err.sv ====
/*
 Self-checking bench of the power domain transition and error block.
 Assumes pdt_pkg is compiled first and pdt_params.svh is on the include path.
*/
`timescale 1ns/1ns
`include "pdt_params.svh"

module tb_power_domain_transition_err;
	import pdt_pkg::*;

	typedef struct {
		logic [11:0] addr;
		logic [31:0] data;
	} row_s;

	logic core_clk = 1'b0;
	logic arst_n = 1'b0;
	reg_req_s req = '0;
	logic [31:0] bus_rdata;
	mod_vec_t mod_event = '0;
	logic dom_event = 1'b0;
	mod_vec_t mod_next = '0;
	mod_vec_t mod_cur = '0;
	mod_vec_t mod_flag_clr, mod_req, mod_target;
	pwr_state_e dom_next = PWR_OFF;
	pwr_state_e dom_cur = PWR_OFF;
	pwr_state_e dom_target;
	logic dom_req, power_sleep_irq, irq;
	int fail_count = 0;
	int tests_run = 0;
	row_s rows [12];

	// 25 MHz clock
	always #20 core_clk = ~core_clk;

	power_domain_transition_err dut_u (.core_clk(core_clk), .arst_n(arst_n),
		.bus_req(req), .bus_rdata(bus_rdata), .mod_event(mod_event),
		.dom_event(dom_event), .mod_flag_clr(mod_flag_clr), .mod_next(mod_next),
		.mod_cur(mod_cur), .dom_next(dom_next), .dom_cur(dom_cur),
		.mod_req(mod_req), .mod_target(mod_target), .dom_req(dom_req),
		.dom_target(dom_target), .power_sleep_irq(power_sleep_irq), .irq(irq));

	// ------------------------------------------------------------------
	// Checking and bus tasks
	// ------------------------------------------------------------------
	task automatic check(input logic [40:0] got, input logic [40:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask

	task automatic complete_run();
		$display("Mismatches %0d of %0d checks", fail_count, tests_run);
		if (fail_count == 0 && tests_run > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// Clear pulses are combinational, so they are looked at mid-cycle
	task automatic reg_wr(input logic [11:0] a, input logic [31:0] d, input mod_vec_t clr);
		@(posedge core_clk);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(negedge core_clk);
		check(mod_flag_clr, clr);
		@(posedge core_clk);
		req.wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic reg_rd(input logic [11:0] a, input logic [31:0] exp);
		@(posedge core_clk);
		req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge core_clk);
		req.rd <= 1'b0;
		@(negedge core_clk);
		check(bus_rdata, exp);
	endtask

	// Bounded so a stuck request cannot hang the run
	task automatic wait_idle();
		int n;
		for (n = 0; n < 50 && (dom_req !== 1'b0 || mod_req !== '0); n++) begin
			@(negedge core_clk);
		end
		if (n == 50) begin
			fail_count++;
			complete_run();
		end
	endtask

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial begin
		rows = '{'{`PDT_OFS_EVAL, 32'h0}, '{`PDT_OFS_MPEND_LO, 32'h0},
			'{`PDT_OFS_MPEND_HI, 32'h0}, '{`PDT_OFS_MCLR_LO, 32'h0},
			'{`PDT_OFS_MCLR_HI, 32'h0}, '{`PDT_OFS_DPEND, 32'h0},
			'{`PDT_OFS_DCLR, 32'h0}, '{`PDT_OFS_TCMD, 32'h0}, '{`PDT_OFS_TSTAT, 32'h0},
			'{`PDT_OFS_ISTAT, 32'h0}, '{`PDT_OFS_IMASK, 32'h0}, '{12'h0FC, 32'h0}};
		repeat (10) @(posedge core_clk);
		check(mod_req, 41'h0);
		check({38'h0, dom_req, irq, power_sleep_irq}, 41'h0);
		check(bus_rdata, 41'h0);
		arst_n <= 1'b1;
		for (int i = 0; i < 12; i++) begin
			reg_rd(rows[i].addr, rows[i].data);
		end
		// Module events at both word edges
		@(posedge core_clk);
		mod_event <= 41'h101_8000_0001;
		@(posedge core_clk);
		mod_event <= '0;
		reg_rd(`PDT_OFS_MPEND_LO, 32'h80000001);
		reg_rd(`PDT_OFS_MPEND_HI, 32'h00000101);
		reg_wr(`PDT_OFS_MCLR_LO, 32'h00000001, 41'h1);
		reg_rd(`PDT_OFS_MPEND_LO, 32'h80000000);
		reg_wr(`PDT_OFS_MCLR_HI, 32'hFFFFFFFF, 41'h1FF_0000_0000);
		reg_rd(`PDT_OFS_MPEND_HI, 32'h0);
		reg_rd(`PDT_OFS_MCLR_HI, 32'h0);
		reg_rd(`PDT_OFS_MPEND_LO, 32'h80000000);
		// Event held through its own clear: the event must win
		@(posedge core_clk);
		mod_event <= 41'h20;
		reg_wr(`PDT_OFS_MCLR_LO, 32'h00000020, 41'h20);
		reg_wr(`PDT_OFS_MCLR_LO, 32'h0, 41'h0);
		mod_event <= '0;
		reg_rd(`PDT_OFS_MPEND_LO, 32'h80000020);
		reg_wr(`PDT_OFS_MCLR_LO, 32'h80000020, 41'h8000_0020);
		reg_rd(`PDT_OFS_MPEND_LO, 32'h0);
		// Domain event, then the interrupt mask and status
		@(posedge core_clk);
		dom_event <= 1'b1;
		@(posedge core_clk);
		dom_event <= 1'b0;
		reg_rd(`PDT_OFS_DPEND, 32'h1);
		check(irq, 1'b0);
		reg_wr(`PDT_OFS_IMASK, 32'h7, 41'h0);
		reg_rd(`PDT_OFS_IMASK, 32'h7);
		reg_rd(`PDT_OFS_ISTAT, 32'h6);
		check(irq, 1'b1);
		reg_wr(`PDT_OFS_ISTAT, 32'h7, 41'h0);
		@(negedge core_clk);
		check(irq, 1'b0);
		// Re-evaluation with the domain still pending
		check(power_sleep_irq, 1'b0);
		reg_wr(`PDT_OFS_EVAL, 32'h0, 41'h0);
		@(negedge core_clk);
		check(power_sleep_irq, 1'b0);
		reg_wr(`PDT_OFS_EVAL, 32'h1, 41'h0);
		@(negedge core_clk);
		check(power_sleep_irq, 1'b1);
		reg_wr(`PDT_OFS_DCLR, 32'h0, 41'h0);
		reg_rd(`PDT_OFS_DPEND, 32'h1);
		reg_wr(`PDT_OFS_DCLR, 32'h1, 41'h0);
		reg_rd(`PDT_OFS_DPEND, 32'h0);
		// Go command: module 0 already matches, module 2 and domain differ
		@(posedge core_clk);
		dom_next <= PWR_ON;
		mod_next <= 41'h5;
		mod_cur <= 41'h1;
		reg_wr(`PDT_OFS_TCMD, 32'h0, 41'h0);
		@(negedge core_clk);
		check(dom_req, 1'b0);
		check(mod_req, 41'h0);
		reg_wr(`PDT_OFS_TCMD, 32'h1, 41'h0);
		@(negedge core_clk);
		check(dom_req, 1'b1);
		check(dom_target, PWR_ON);
		check(mod_req, 41'h4);
		check(mod_target[2], 1'b1);
		reg_rd(`PDT_OFS_TSTAT, 32'h1);
		@(posedge core_clk);
		dom_cur <= PWR_ON;
		mod_cur <= 41'h5;
		wait_idle();
		reg_rd(`PDT_OFS_TSTAT, 32'h0);
		reg_rd(`PDT_OFS_ISTAT, 32'h1);
		check(irq, 1'b1);
		complete_run();
	end
endmodule
